//--- common/ssb_pkg.sv
// constants of the serial status and data buffer block
// assumes one bus clock at 40 MHz and a byte-wide register port
package ssb_pkg;

    // register port
    localparam int          ADDR_W     = 4;
    localparam int          DATA_W     = 8;
    localparam logic [3:0]  OFF_CTRL1  = 4'h0;
    localparam logic [3:0]  OFF_CTRL2  = 4'h4;
    localparam logic [3:0]  OFF_STATUS = 4'h8;
    localparam logic [3:0]  OFF_DATA   = 4'hC;

    // control register one fields
    localparam int C1_RF_IRQ_EN = 7;
    localparam int C1_ENABLE    = 6;
    localparam int C1_TX_IRQ_EN = 5;
    localparam int C1_MASTER    = 4;
    localparam int C1_SS_OUT_EN = 1;
    localparam int C1_LSB_FIRST = 0;

    // control register two fields
    localparam int C2_FAULT_EN  = 4;

    // status fields
    localparam int ST_RX_FULL   = 7;
    localparam int ST_TX_EMPTY  = 5;
    localparam int ST_MODE_FLT  = 4;

    // reset values
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] DATA_RST  = 8'h00;

    // serial framing
    localparam int         BITS_PER_XFER = 8;
    localparam logic [2:0] LAST_BIT      = 3'h7;

    // timing
    localparam int CLK_PERIOD_NS  = 25;
    localparam int SCK_PERIOD_NS  = 200;
    localparam int SCK_HALF_CYC   = (SCK_PERIOD_NS / 2) / CLK_PERIOD_NS;
    localparam int TEF_SET_CYC    = 2;

endpackage : ssb_pkg

//--- sim/ssb_peer.sv
// external serial slave model for the status and data buffer block
// assumes clock format 0: clock idles low, sample on rise, shift on fall
`timescale 1ns/1ps
`default_nettype none
module ssb_peer (
    // serial pins as seen on the board
    input  wire logic       sck_i,
    input  wire logic       ss_b_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    // observation
    output logic [7:0]      rx_o,
    output int              frames_o
);
    logic [7:0] tx_reg;
    logic [7:0] sh_reg;
    logic       sck_q;
    logic       ss_q;

    // one process drives every output; unknown pins at start give no edge
    initial
    begin
        miso_o   = 1'h0;
        rx_o     = 8'h00;
        frames_o = 0;
        tx_reg   = 8'h00;
        sh_reg   = 8'h00;
        sck_q    = 1'h0;
        ss_q     = 1'h1;
        forever
        begin
            @(sck_i or ss_b_i);
            if (ss_q && !ss_b_i)
            begin
                // reply byte changes every frame so a dropped byte is visible
                tx_reg = 8'hA0 + frames_o[7:0];
                miso_o = tx_reg[7];
            end
            else if (!ss_q && ss_b_i)
            begin
                // released line: inverse of last bit, never a stale copy
                rx_o     = sh_reg;
                frames_o = frames_o + 1;
                miso_o   = ~miso_o;
            end
            else if (!ss_b_i && !sck_q && sck_i)
                sh_reg = {sh_reg[6:0], mosi_i};
            else if (!ss_b_i && sck_q && !sck_i)
            begin
                tx_reg = {tx_reg[6:0], 1'h0};
                miso_o = tx_reg[7];
            end
            sck_q = sck_i;
            ss_q  = ss_b_i;
        end
    end
endmodule : ssb_peer
`default_nettype wire

//--- sim/tb_ssb_top.sv
// self-checking bench for the serial status and data buffer block
// assumes ssb_pkg compiled first and the peer model beside it
`timescale 1ns/1ps
`default_nettype none
module tb_ssb_top;
    localparam logic [3:0] C1 = ssb_pkg::OFF_CTRL1;
    localparam logic [3:0] C2 = ssb_pkg::OFF_CTRL2;
    localparam logic [3:0] ST = ssb_pkg::OFF_STATUS;
    localparam logic [3:0] DT = ssb_pkg::OFF_DATA;

    logic       clk, rst_b, wr, rd, ss_drv, irq, peer_miso, sck_drv, mosi_drv;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, peer_rx, dummy;
    logic       sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
    int         peer_frames, n_errors, total_checks;

    // board level: bench drives select, clock and data wherever the block lets go
    wire logic  ss_w   = ss_oe ? ss_o : ss_drv;
    wire logic  sck_w  = sck_oe ? sck_o : sck_drv;
    wire logic  mosi_w = mosi_oe ? mosi_o : mosi_drv;
    wire logic  miso_w = miso_oe ? miso_o : peer_miso;

    ssb_top #(.HALF_DIV(4)) ssb_top_inst (
        .CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE_O(sck_oe), .MOSI_I(mosi_w),
        .MOSI_O(mosi_o), .MOSI_OE_O(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o),
        .MISO_OE_O(miso_oe), .SS_B_I(ss_w), .SS_B_O(ss_o), .SS_OE_O(ss_oe), .IRQ_O(irq));

    ssb_peer ssb_peer_inst (.sck_i(sck_w), .ss_b_i(ss_w), .mosi_i(mosi_w), .miso_o(peer_miso),
        .rx_o(peer_rx), .frames_o(peer_frames));

    initial
    begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge clk);
        wr    <= 1'h0;
    endtask : wr_reg

    task rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'h1;
        @(posedge clk);
        rd   <= 1'h0;
        #1 d = rdata;
    endtask : rd_reg

    task chk_reg(input string name, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd_reg(a, d);
        chk(name, d, exp);
    endtask : chk_reg

    task chk_irq(input logic e);
        repeat (3) @(posedge clk);
        #1 chk("irq", {7'h00, irq}, {7'h00, e});
    endtask : chk_irq

    // bounded wait on the peer's frame count, then let the flags settle
    task wait_frames(input int n);
        int k;
        k = 0;
        while (peer_frames < n && k < 3000)
        begin
            @(posedge clk);
            k++;
        end
        repeat (8) @(posedge clk);
        chk("frames", 8'(peer_frames), 8'(n));
    endtask : wait_frames

    // bench as serial master for the block in slave mode, clock format 0, 200 ns clock
    task slv_byte(input logic [7:0] d, output logic [7:0] q);
        int i;
        @(posedge clk);
        ss_drv <= 1'h0;
        for (i = 7; i >= 0; i--)
        begin
            mosi_drv <= d[i];
            repeat (4) @(posedge clk);
            sck_drv <= 1'h1;
            repeat (2) @(posedge clk);
            #1 q[i] = miso_w;
            repeat (2) @(posedge clk);
            sck_drv <= 1'h0;
        end
        repeat (4) @(posedge clk);
        ss_drv <= 1'h1;
        repeat (4) @(posedge clk);
    endtask : slv_byte

    task summarize;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    initial
    begin
        #500000;
        n_errors++;
        $display("watchdog expired");
        summarize();
    end

    initial
    begin
        rst_b = 1'h0; wr = 1'h0; rd = 1'h0; addr = 4'h0; wdata = 8'h00; ss_drv = 1'h1;
        n_errors = 0; total_checks = 0;
        sck_drv = 1'h0; mosi_drv = 1'h1;
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        chk_reg("unmapped", 4'h2, 8'h00);
        chk_irq(1'h0);
        $display("test reset done");
        // write before any status read must not start a frame
        wr_reg(C2, 8'h10);
        wr_reg(C1, 8'h52);
        wr_reg(DT, 8'h99);
        repeat (150) @(posedge clk);
        chk("frames", 8'(peer_frames), 8'h00);
        chk_reg("status", ST, 8'h20);
        wr_reg(DT, 8'h3C);
        repeat (2) @(posedge clk);
        chk_reg("status", ST, 8'h20);
        wr_reg(DT, 8'hC5);
        chk_reg("status", ST, 8'h00);
        wait_frames(1);
        chk("peer rx", peer_rx, 8'h3C);
        wait_frames(2);
        chk("peer rx", peer_rx, 8'hC5);
        chk_reg("data", DT, 8'hA0);
        chk_reg("status", ST, 8'hA0);
        chk_reg("data", DT, 8'hA0);
        chk_reg("status", ST, 8'h20);
        $display("test master queue done");
        wr_reg(C1, 8'hF3);
        chk_irq(1'h1);
        wr_reg(C1, 8'hD3);
        chk_irq(1'h0);
        rd_reg(ST, dummy);
        wr_reg(DT, 8'h1E);
        wait_frames(3);
        chk("peer rx", peer_rx, 8'h78);
        chk_irq(1'h1);
        chk_reg("status", ST, 8'hA0);
        chk_reg("data", DT, 8'h45);
        chk_irq(1'h0);
        $display("test lsb first done");
        @(posedge clk);
        ss_drv <= 1'h0;
        wr_reg(C2, 8'h00);
        wr_reg(C1, 8'hD0);
        chk_reg("status", ST, 8'h20);
        wr_reg(C1, 8'hD2);
        wr_reg(C2, 8'h10);
        chk_reg("status", ST, 8'h20);
        wr_reg(C1, 8'hD0);
        // select output enable drops one cycle later, then two sync stages
        repeat (4) @(posedge clk);
        chk_reg("status", ST, 8'h30);
        chk_irq(1'h1);
        @(posedge clk);
        ss_drv <= 1'h1;
        // a fault still seen through the synchroniser would cancel the arming read
        repeat (4) @(posedge clk);
        chk_reg("status", ST, 8'h30);
        wr_reg(C1, 8'h50);
        chk_reg("status", ST, 8'h20);
        chk_irq(1'h0);
        $display("test mode fault done");
        wr_reg(C1, 8'h40);
        chk_reg("status", ST, 8'h20);
        wr_reg(DT, 8'h96);
        slv_byte(8'h5A, dummy);
        chk("slave miso", dummy, 8'h96);
        chk_reg("status", ST, 8'hA0);
        chk_reg("data", DT, 8'h5A);
        $display("test slave done");
        summarize();
    end
endmodule : tb_ssb_top
`default_nettype wire

//--- verilog/ssb_top.sv
// serial status flags, double-buffered data register and byte shifter
// assumes a single-cycle register port and external serial pins on another clock
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module ssb_top #(
    parameter int HALF_DIV = ssb_pkg::SCK_HALF_CYC
) (
    // clock and reset
    input  wire logic                      CLK_I,
    input  wire logic                      RST_B_I,
    // register port
    input  wire logic [ssb_pkg::ADDR_W-1:0] ADDR_I,
    input  wire logic [ssb_pkg::DATA_W-1:0] WDATA_I,
    input  wire logic                      WR_I,
    input  wire logic                      RD_I,
    output logic      [ssb_pkg::DATA_W-1:0] RDATA_O,
    // serial clock pin
    input  wire logic                      SCK_I,
    output logic                           SCK_O,
    output logic                           SCK_OE_O,
    // master out data pin
    input  wire logic                      MOSI_I,
    output logic                           MOSI_O,
    output logic                           MOSI_OE_O,
    // master in data pin
    input  wire logic                      MISO_I,
    output logic                           MISO_O,
    output logic                           MISO_OE_O,
    // slave select pin
    input  wire logic                      SS_B_I,
    output logic                           SS_B_O,
    output logic                           SS_OE_O,
    // interrupt request
    output logic                           IRQ_O
);

    function automatic logic hit(input logic [ssb_pkg::ADDR_W-1:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic logic out_bit(input logic [7:0] s, input logic lsb);
        out_bit = lsb ? s[0] : s[7];
    endfunction : out_bit

    function automatic logic [7:0] tx_shift(input logic [7:0] s, input logic lsb);
        tx_shift = lsb ? {1'b0, s[7:1]} : {s[6:0], 1'b0};
    endfunction : tx_shift

    function automatic logic [7:0] rx_shift_in(input logic [7:0] s, input logic b, input logic lsb);
        rx_shift_in = lsb ? {b, s[7:1]} : {s[6:0], b};
    endfunction : rx_shift_in

    // pin synchronisers: index 3 sck, 2 mosi, 1 miso, 0 select
    logic [3:0]  sync1_reg;
    logic [3:0]  sync2_reg;
    logic        sck_prev_reg;

    logic [7:0]  ctrl1_reg;
    logic [7:0]  ctrl2_reg;
    logic [7:0]  rdata_reg;
    logic [7:0]  txbuf_reg;
    logic        txbuf_full_reg;
    logic [7:0]  rxbuf_reg;
    logic [7:0]  shift_reg;
    logic        shift_loaded_reg;
    logic [7:0]  rx_reg;
    logic [2:0]  bit_cnt_reg;
    logic [15:0] div_cnt_reg;
    logic        running_reg;
    logic        sck_reg;
    logic        ss_out_reg;
    logic        rf_flag_reg;
    logic        tef_flag_reg;
    logic        mode_fault_flag_flag_reg;
    logic        rf_armed_reg;
    logic        tef_armed_reg;
    logic        mode_fault_flag_armed_reg;
    logic        sck_oe_reg;
    logic        mosi_reg;
    logic        mosi_oe_reg;
    logic        miso_reg;
    logic        miso_oe_reg;
    logic        ss_oe_reg;
    logic        irq_reg;

    logic        enable;
    logic        master;
    logic        lsb_first;
    logic        fault_cond;
    logic        slave_sel;
    logic        sck_rise;
    logic        sck_fall;
    logic        tick;
    logic        m_rise;
    logic        m_fall;
    logic        xfer_done;
    logic [7:0]  rx_byte;
    logic        load_now;
    logic        wr_data;
    logic        rd_data;
    logic        rd_status;
    logic        wr_ctrl1;
    logic        data_accept;

    assign enable    = ctrl1_reg[ssb_pkg::C1_ENABLE];
    assign master    = ctrl1_reg[ssb_pkg::C1_MASTER];
    assign lsb_first = ctrl1_reg[ssb_pkg::C1_LSB_FIRST];
    assign wr_data   = WR_I && hit(ADDR_I, ssb_pkg::OFF_DATA);
    assign rd_data   = RD_I && hit(ADDR_I, ssb_pkg::OFF_DATA);
    assign rd_status = RD_I && hit(ADDR_I, ssb_pkg::OFF_STATUS);
    assign wr_ctrl1  = WR_I && hit(ADDR_I, ssb_pkg::OFF_CTRL1);

    // select pin is a fault input only in this one configuration
    assign fault_cond = enable && master && ctrl2_reg[ssb_pkg::C2_FAULT_EN]
                        && !ctrl1_reg[ssb_pkg::C1_SS_OUT_EN] && !sync2_reg[0];

    assign slave_sel = enable && !master && !sync2_reg[0];
    assign sck_rise  = sync2_reg[3] && !sck_prev_reg;
    assign sck_fall  = !sync2_reg[3] && sck_prev_reg;
    assign tick      = running_reg && (div_cnt_reg == 16'(HALF_DIV - 1));
    assign m_rise    = tick && !sck_reg;
    assign m_fall    = tick && sck_reg;

    // eight sampled bits end a transfer
    assign xfer_done = master ? (m_fall && bit_cnt_reg == ssb_pkg::LAST_BIT)
                              : (slave_sel && sck_rise && bit_cnt_reg == ssb_pkg::LAST_BIT);
    assign rx_byte   = master ? rx_reg : rx_shift_in(rx_reg, sync2_reg[2], lsb_first);

    // queued byte enters an empty shifter, or one that just finished
    assign load_now    = enable && txbuf_full_reg && (!shift_loaded_reg || xfer_done);
    assign data_accept = wr_data && tef_armed_reg && tef_flag_reg;

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            // idle levels: sck low, mosi high, miso high, select high; no false edge after reset
            sync1_reg    <= 4'h7;
            sync2_reg    <= 4'h7;
            sck_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg    <= {SCK_I, MOSI_I, MISO_I, SS_B_I};
            sync2_reg    <= sync1_reg;
            sck_prev_reg <= sync2_reg[3];
        end
    end

    // control registers and read data
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            ctrl1_reg <= ssb_pkg::CTRL1_RST;
            ctrl2_reg <= ssb_pkg::CTRL2_RST;
            rdata_reg <= ssb_pkg::DATA_RST;
        end
        else
        begin
            if (wr_ctrl1)
                ctrl1_reg <= WDATA_I;
            if (WR_I && hit(ADDR_I, ssb_pkg::OFF_CTRL2))
                ctrl2_reg <= WDATA_I;
            if (RD_I)
            begin
                rdata_reg <= ssb_pkg::DATA_RST;
                if (hit(ADDR_I, ssb_pkg::OFF_CTRL1))
                    rdata_reg <= ctrl1_reg;
                else if (hit(ADDR_I, ssb_pkg::OFF_CTRL2))
                    rdata_reg <= ctrl2_reg;
                else if (rd_status)
                begin
                    rdata_reg[ssb_pkg::ST_RX_FULL]  <= rf_flag_reg;
                    rdata_reg[ssb_pkg::ST_TX_EMPTY] <= tef_flag_reg;
                    rdata_reg[ssb_pkg::ST_MODE_FLT] <= mode_fault_flag_flag_reg;
                end
                else if (rd_data)
                    rdata_reg <= rxbuf_reg;
            end
        end
    end

    // transmit buffer; software should only write while there is room
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            txbuf_reg      <= ssb_pkg::DATA_RST;
            txbuf_full_reg <= 1'b0;
        end
        else if (data_accept)
        begin
            txbuf_reg      <= WDATA_I;
            txbuf_full_reg <= 1'b1;
        end
        else if (load_now)
            txbuf_full_reg <= 1'b0;
    end

    // receive buffer; an unread byte is kept and the new one lost silently
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            rxbuf_reg <= ssb_pkg::DATA_RST;
        else if (xfer_done && !rf_flag_reg)
            rxbuf_reg <= rx_byte;
    end

    // status flags with their two-step clear; a hardware set always wins
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            rf_flag_reg    <= 1'b0;
            tef_flag_reg   <= 1'b1;
            mode_fault_flag_flag_reg  <= 1'b0;
            rf_armed_reg   <= 1'b0;
            tef_armed_reg  <= 1'b0;
            mode_fault_flag_armed_reg <= 1'b0;
        end
        else
        begin
            if (xfer_done)
            begin
                rf_flag_reg  <= 1'b1;
                rf_armed_reg <= 1'b0;
            end
            else if (rd_data && rf_armed_reg)
            begin
                rf_flag_reg  <= 1'b0;
                rf_armed_reg <= 1'b0;
            end
            else if (rd_status)
                rf_armed_reg <= rf_flag_reg;

            if (load_now)
            begin
                tef_flag_reg  <= 1'b1;
                tef_armed_reg <= 1'b0;
            end
            else if (wr_data)
            begin
                if (data_accept)
                    tef_flag_reg <= 1'b0;
                tef_armed_reg <= 1'b0;
            end
            else if (rd_status)
                tef_armed_reg <= tef_flag_reg;

            if (fault_cond)
            begin
                mode_fault_flag_flag_reg  <= 1'b1;
                mode_fault_flag_armed_reg <= 1'b0;
            end
            else if (wr_ctrl1 && mode_fault_flag_armed_reg)
            begin
                mode_fault_flag_flag_reg  <= 1'b0;
                mode_fault_flag_armed_reg <= 1'b0;
            end
            else if (rd_status)
                mode_fault_flag_armed_reg <= mode_fault_flag_flag_reg;
        end
    end

    // shifter contents
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            shift_reg        <= ssb_pkg::DATA_RST;
            shift_loaded_reg <= 1'b0;
        end
        else if (load_now)
        begin
            shift_reg        <= txbuf_reg;
            shift_loaded_reg <= 1'b1;
        end
        else if (xfer_done)
            shift_loaded_reg <= 1'b0;
        else if ((master && m_fall) || (slave_sel && sck_fall && bit_cnt_reg != 3'h0))
            shift_reg <= tx_shift(shift_reg, lsb_first);
    end

    // bit timing: master makes sck, slave follows the sampled pin
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            running_reg <= 1'b0;
            sck_reg     <= 1'b0;
            ss_out_reg  <= 1'b1;
            div_cnt_reg <= 16'h0000;
            bit_cnt_reg <= 3'h0;
            rx_reg      <= ssb_pkg::DATA_RST;
        end
        else if (master)
        begin
            if (fault_cond || !enable)
            begin
                running_reg <= 1'b0;
                sck_reg     <= 1'b0;
                ss_out_reg  <= 1'b1;
            end
            else if (!running_reg && shift_loaded_reg)
            begin
                running_reg <= 1'b1;
                ss_out_reg  <= 1'b0;
                div_cnt_reg <= 16'h0000;
                bit_cnt_reg <= 3'h0;
            end
            else if (running_reg)
            begin
                div_cnt_reg <= tick ? 16'h0000 : div_cnt_reg + 16'h0001;
                if (tick)
                    sck_reg <= !sck_reg;
                if (m_rise)
                    rx_reg <= rx_shift_in(rx_reg, sync2_reg[1], lsb_first);
                if (m_fall)
                begin
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    if (bit_cnt_reg == ssb_pkg::LAST_BIT)
                    begin
                        running_reg <= 1'b0;
                        ss_out_reg  <= 1'b1;
                    end
                end
            end
        end
        else
        begin
            running_reg <= 1'b0;
            sck_reg     <= 1'b0;
            ss_out_reg  <= 1'b1;
            if (!slave_sel)
                bit_cnt_reg <= 3'h0;
            else if (sck_rise)
            begin
                rx_reg      <= rx_shift_in(rx_reg, sync2_reg[2], lsb_first);
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
        end
    end

    // pin drivers and interrupt, all registered
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            sck_oe_reg  <= 1'b0;
            mosi_reg    <= 1'b0;
            mosi_oe_reg <= 1'b0;
            miso_reg    <= 1'b0;
            miso_oe_reg <= 1'b0;
            ss_oe_reg   <= 1'b0;
            irq_reg     <= 1'b0;
        end
        else
        begin
            sck_oe_reg  <= enable && master;
            mosi_reg    <= out_bit(shift_reg, lsb_first);
            mosi_oe_reg <= enable && master;
            miso_reg    <= out_bit(shift_reg, lsb_first);
            miso_oe_reg <= slave_sel;
            ss_oe_reg   <= enable && master && ctrl2_reg[ssb_pkg::C2_FAULT_EN]
                           && ctrl1_reg[ssb_pkg::C1_SS_OUT_EN];
            irq_reg     <= (tef_flag_reg && ctrl1_reg[ssb_pkg::C1_TX_IRQ_EN])
                           || ((rf_flag_reg || mode_fault_flag_flag_reg) && ctrl1_reg[ssb_pkg::C1_RF_IRQ_EN]);
        end
    end

    assign RDATA_O   = rdata_reg;
    assign SCK_O     = sck_reg;
    assign SCK_OE_O  = sck_oe_reg;
    assign MOSI_O    = mosi_reg;
    assign MOSI_OE_O = mosi_oe_reg;
    assign MISO_O    = miso_reg;
    assign MISO_OE_O = miso_oe_reg;
    assign SS_B_O    = ss_out_reg;
    assign SS_OE_O   = ss_oe_reg;
    assign IRQ_O     = irq_reg;

    localparam int TEF_WAIT = ssb_pkg::TEF_SET_CYC;

    rf_set_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        xfer_done |=> rf_flag_reg)
        else $error("receive-full not set after transfer");

    rf_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        rf_flag_reg && !rf_armed_reg |=> rf_flag_reg)
        else $error("receive-full cleared without status read");

    tef_room_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        tef_flag_reg == !txbuf_full_reg)
        else $error("transmit-empty disagrees with buffer room");

    wr_drop_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        wr_data && !tef_armed_reg |=> $stable(txbuf_reg) && tef_flag_reg == $past(tef_flag_reg) || $past(load_now))
        else $error("unarmed data write was taken");

    tx_irq_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        tef_flag_reg && ctrl1_reg[ssb_pkg::C1_TX_IRQ_EN] |=> IRQ_O)
        else $error("missing transmit interrupt");

    idle_load_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        data_accept && enable && !shift_loaded_reg && !running_reg |-> ##[1:TEF_WAIT] tef_flag_reg)
        else $error("transmit-empty late on idle write");

    fault_src_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        $rose(mode_fault_flag_flag_reg) |-> $past(fault_cond))
        else $error("mode fault outside fault configuration");

    mode_fault_flag_clr_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        wr_ctrl1 && mode_fault_flag_armed_reg && !fault_cond |=> !mode_fault_flag_flag_reg)
        else $error("mode fault not cleared");

    overrun_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        xfer_done && rf_flag_reg |=> $stable(rxbuf_reg))
        else $error("overrun replaced receive buffer");

    m_start_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        load_now && master && !running_reg && !fault_cond |-> ##[1:2] (running_reg || fault_cond))
        else $error("master did not start transfer");

endmodule : ssb_top

`default_nettype wire
